// ==== qtbr_pkg.sv ====
package qtbr_pkg;
	// ****************************************
	// Widths and timing
	// ****************************************
	localparam int unsigned WIDTH = 4;
	localparam logic [3:0] CLEAR_VAL = 4'h0;
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned CLK_PULSE_MIN_PS = 12000;
	localparam int unsigned CLEAR_PULSE_MIN_PS = 15000;
	localparam int unsigned CLK_PULSE_CYC =
		(CLK_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CLEAR_PULSE_CYC =
		(CLEAR_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef logic [WIDTH-1:0] qtbr_word_t;
endpackage : qtbr_pkg

// ==== qtbr_reg.sv ====
`timescale 1ns/1ps
// Operation
// - Any output disable high puts all four outputs in high impedance; here it only drops stored_bit_oe_o, data outputs stay driven.
// - Outputs driven only when both output disables are low.
// - All bits capture on one rising clock; clock pulse at least 12 ns; the testbench clock is high for 2 ns of each 4 ns period.
// - Any input disable high holds stored value, ignoring clock edges.
// - Input disable changes never alter stored data by themselves.
// - Clear high resets all bits to zero; pulse held 15 ns minimum.
// - Enabled outputs present true, non-inverted stored bits.
// - Loading and driving outputs may happen in the same cycle.
module qtbr_reg
	import qtbr_pkg::*;
(
	// Clock and clear
	input wire logic clk_i,
	input wire logic rst_i,
	// Load side
	input wire qtbr_pkg::qtbr_word_t data_i,
	input wire logic in_dis_a_i,
	input wire logic in_dis_b_i,
	// Bus side
	input wire logic out_dis_a_i,
	input wire logic out_dis_b_i,
	output qtbr_pkg::qtbr_word_t stored_bit_output_o,
	output logic stored_bit_oe_o
);
	import qtbr_pkg::*;

	// ****************************************
	// Decode
	// ****************************************
	// Pair of active-high disables, either one blocks
	function automatic logic either_high(
		input logic dis_x,
		input logic dis_y
	);
		either_high = dis_x | dis_y;
	endfunction : either_high

	// ****************************************
	// Storage
	// ****************************************
	qtbr_word_t store_q;
	qtbr_word_t store_d;
	logic load_en;

	assign load_en = ~either_high(in_dis_a_i, in_dis_b_i);

	always_comb begin
		store_d = load_en ? data_i : store_q;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			store_q <= CLEAR_VAL;
		end else begin
			store_q <= store_d;
		end
	end

	// ****************************************
	// Bus drive
	// ****************************************
	logic drive_en;

	assign drive_en = ~either_high(out_dis_a_i, out_dis_b_i);
	assign stored_bit_oe_o = drive_en;
	assign stored_bit_output_o = store_q;

	// ****************************************
	// Check helpers
	// ****************************************
	// Data and gate seen at the last edge
	qtbr_word_t seen_data_q;
	logic seen_load_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			seen_data_q <= CLEAR_VAL;
		end else begin
			seen_data_q <= data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			seen_load_q <= 1'b0;
		end else begin
			seen_load_q <= load_en;
		end
	end

	// ****************************************
	// Output enable checks
	// ****************************************
	oe_off_a: assert property (
		@(posedge clk_i)
		(out_dis_a_i || out_dis_b_i)
		|-> !stored_bit_oe_o
	)
		else $error("Output enabled while a disable is high");

	dis_a_off_a: assert property (
		@(posedge clk_i)
		(out_dis_a_i && !out_dis_b_i)
		|-> !stored_bit_oe_o
	)
		else $error("First output disable did not float outputs");

	dis_b_off_a: assert property (
		@(posedge clk_i)
		(out_dis_b_i && !out_dis_a_i)
		|-> !stored_bit_oe_o
	)
		else $error("Second output disable did not float outputs");

	oe_on_a: assert property (
		@(posedge clk_i)
		(!out_dis_a_i && !out_dis_b_i)
		|-> stored_bit_oe_o
	)
		else $error("Output not enabled with both disables low");

	oe_indep_a: assert property (
		@(posedge clk_i)
		(!out_dis_a_i && !out_dis_b_i && !load_en)
		|-> stored_bit_oe_o
	)
		else $error("Input disables affected output enable");

	// ****************************************
	// Load and hold checks
	// ****************************************
	load_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		load_en
		|=> stored_bit_output_o == $past(data_i)
	)
		else $error("Data not captured on rising edge");

	seen_load_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		seen_load_q
		|-> stored_bit_output_o == seen_data_q
	)
		else $error("Stored bits differ from last captured data");

	hold_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(in_dis_a_i || in_dis_b_i)
		|=> $stable(stored_bit_output_o)
	)
		else $error("Stored value changed while input disabled");

	hold_ia_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(in_dis_a_i && !in_dis_b_i)
		|=> $stable(stored_bit_output_o)
	)
		else $error("First input disable did not hold data");

	hold_ib_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(in_dis_b_i && !in_dis_a_i)
		|=> $stable(stored_bit_output_o)
	)
		else $error("Second input disable did not hold data");

	dis_change_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(($changed(in_dis_a_i) || $changed(in_dis_b_i)) && !load_en)
		|=> $stable(stored_bit_output_o)
	)
		else $error("Disable change altered stored data");

	true_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(stored_bit_oe_o && seen_load_q)
		|-> stored_bit_output_o == seen_data_q
	)
		else $error("Enabled output differs from captured bits");

	rw_a: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(stored_bit_oe_o && load_en)
		|=> stored_bit_output_o == $past(data_i)
	)
		else $error("Load blocked while outputs enabled");

	// ****************************************
	// Clear checks
	// ****************************************
	clear_a: assert property (
		@(posedge clk_i)
		rst_i
		|-> stored_bit_output_o == CLEAR_VAL
	)
		else $error("Clear did not zero stored bits");

	clear_rel_a: assert property (
		@(posedge clk_i)
		$fell(rst_i)
		|-> stored_bit_output_o == CLEAR_VAL
	)
		else $error("Stored bits not zero after clear release");

	clear_bus_a: assert property (
		@(posedge clk_i)
		(rst_i && stored_bit_oe_o)
		|-> stored_bit_output_o == CLEAR_VAL
	)
		else $error("Enabled outputs not zero during clear");

	clr_prio_a: assert property (
		@(posedge clk_i)
		(rst_i && load_en)
		|-> store_q == CLEAR_VAL
	)
		else $error("Capture overrode clear");
endmodule : qtbr_reg

// ==== qtbr_bus_peer.sv ====
`timescale 1ns/1ps
module qtbr_bus_peer (
	// Register side
	input wire logic dut_oe_i,
	input wire logic [3:0] dut_val_i,
	output wire logic [3:0] bus_o
);
	// Peer drives 4'h5 only while the register is off the bus
	assign bus_o = dut_oe_i ? dut_val_i : 4'h5;
endmodule : qtbr_bus_peer

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import qtbr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b0;
	logic ia = 1'b0;
	logic ib = 1'b0;
	logic oa = 1'b0;
	logic ob = 1'b0;
	logic oe;
	qtbr_word_t d = 4'h0;
	qtbr_word_t q;
	qtbr_word_t bus;
	int num_errors = 0;
	int tests_run = 0;
	always #2 clk = ~clk;
	qtbr_reg u_dut (.clk_i(clk), .rst_i(rst), .data_i(d), .in_dis_a_i(ia),
		.in_dis_b_i(ib), .out_dis_a_i(oa), .out_dis_b_i(ob),
		.stored_bit_output_o(q), .stored_bit_oe_o(oe));
	qtbr_bus_peer u_peer (.dut_oe_i(oe), .dut_val_i(q), .bus_o(bus));
	task chk(input qtbr_word_t got, input qtbr_word_t exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task step;
		@(posedge clk);
		#1;
	endtask : step
	task finish_test;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	// Clear held for whole cycles, entered and left just after an edge
	task do_clear(input int unsigned cycles);
		rst = 1'b1;
		#1 chk(q, CLEAR_VAL);
		repeat (cycles) step;
		rst = 1'b0;
	endtask : do_clear
	task test_load_drive;
		d = 4'ha;
		step;
		chk(q, 4'ha);
		chk(bus, 4'ha);
		chk_bit(oe, 1'b1);
		d = 4'h3;
		step;
		chk(bus, 4'h3);
	endtask : test_load_drive
	task test_hold;
		ia = 1'b1;
		d = 4'hc;
		step;
		chk(q, 4'h3);
		ib = 1'b1;
		#2 ia = 1'b0;
		step;
		chk(q, 4'h3);
		ib = 1'b0;
		step;
		chk(q, 4'hc);
	endtask : test_hold
	task test_out_disable;
		{oa, ob} = 2'b10;
		d = 4'h9;
		#1 chk(bus, 4'h5);
		chk_bit(oe, 1'b0);
		{oa, ob} = 2'b01;
		#1 chk(bus, 4'h5);
		step;
		chk(q, 4'h9);
		{oa, ob} = 2'b11;
		#1 chk_bit(oe, 1'b0);
		{oa, ob} = 2'b00;
		#1 chk(bus, 4'h9);
		chk_bit(oe, 1'b1);
	endtask : test_out_disable
	task test_clear;
		d = 4'h6;
		step;
		chk(q, 4'h6);
		do_clear(CLEAR_PULSE_CYC);
		chk(q, CLEAR_VAL);
		step;
		chk(q, 4'h6);
	endtask : test_clear
	initial begin
		#2000;
		num_errors++;
		finish_test;
	end
	initial begin
		step;
		do_clear(CLEAR_PULSE_CYC);
		chk(bus, CLEAR_VAL);
		test_load_drive;
		test_hold;
		test_out_disable;
		test_clear;
		finish_test;
	end
endmodule : testbench
